// file: design/rfq_div.sv
`timescale 1ns/1ns
module rfq_div #(
  parameter int CNT_W = 3
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic src_edge,
  input wire logic bypass,
  input wire logic [1:0] div_sel,
  output logic tick
);
  import rfq_pkg::*;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic tick;
  } rfq_div_state_t;

  rfq_div_state_t st;
  rfq_div_state_t next_st;
  logic [CNT_W-1:0] lim;

  if (CNT_W < 3) begin : g_narrow_count
    $error("rfq_div counter too narrow for divide by eight");
  end

  always_comb begin
    next_st = st;
    lim = CNT_W'((4'h1 << div_sel) - 4'h1);
    next_st.tick = 1'b0;
    if (src_edge) begin
      if (bypass || st.cnt >= lim) begin // [R07] [R08]
        next_st.cnt = '0;
        next_st.tick = 1'b1;
      end else begin
        next_st.cnt = st.cnt + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick = st.tick;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_slow_undivided;
    bypass && src_edge |=> tick;
  endproperty
  a_slow_undivided: assert property (p_slow_undivided) else $error("bypass edge gave no tick"); // [R07]

  property p_div_hold;
    !bypass && src_edge && (st.cnt < lim) |=> !tick;
  endproperty
  a_div_hold: assert property (p_div_hold) else $error("divider ticked early"); // [R08]

  property p_div_fire;
    !bypass && src_edge && (st.cnt == lim) |=> tick && (st.cnt == '0);
  endproperty
  a_div_fire: assert property (p_div_fire) else $error("divider missed its tick"); // [R08]

  c_div_eight: cover property (!bypass && div_sel == 2'h3 && src_edge && st.cnt == 3'h7);
endmodule : rfq_div

// file: design/rfq_pkg.sv
package rfq_pkg;
  localparam int ADR_W = 8;
  localparam logic [7:0] CLK_REG_OFS = 8'h00;
  localparam logic [7:0] CTL_REG_OFS = 8'h04;
  localparam logic [7:0] TRG_REG_OFS = 8'h08;
  localparam logic [7:0] PIN_REG_OFS = 8'h0c;
  localparam logic [7:0] STAT_REG_OFS = 8'h10;
  localparam int CLK_SRC_LSB = 0;
  localparam int CLK_DIV_LSB = 4;
  localparam int CLK_GATE_BIT = 8;
  localparam int CTL_EN_BIT = 0;
  localparam int CTL_CHAN_BIT = 1;
  localparam int CTL_CFG_LSB = 4;
  localparam int CFG_W = 4;
  localparam int TRG_REF_BIT = 0;
  localparam int TRG_SA_BIT = 1;
  localparam int TRG_SB_BIT = 2;
  localparam logic [1:0] CLK_SRC_RST = 2'h0;
  localparam logic [1:0] CLK_DIV_RST = 2'h0;
  localparam logic CLK_GATE_RST = 1'h0;
  localparam logic CHAN_SEL_RST = 1'h0;
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic [1:0] SRC_HS_B = 2'h0;
  localparam logic [1:0] SRC_LS = 2'h1;
  localparam logic [1:0] SRC_HS_A = 2'h2;
  localparam logic [1:0] SRC_RSVD = 2'h3;
  localparam logic [1:0] MODE_DC = 2'h0;
  localparam logic [1:0] MODE_AC = 2'h1;

  typedef enum logic [1:0] {PH_IDLE, PH_REF, PH_SENS_A, PH_SENS_B} rfq_phase_t;

  typedef struct packed {
    logic [1:0] osc_mode_sel;
    logic event_counter_en;
    logic continuous_osc_en;
  } rfq_chan_cfg_t;

  typedef struct packed {
    logic [1:0] sensor_b_ctrl_pin;
    logic [1:0] sensor_a_ctrl_pin;
    logic [1:0] reference_ctrl_pin;
    logic [1:0] osc_clock_input_pin;
  } rfq_pins_t;
endpackage : rfq_pkg

// file: design/rfq_sync.sv
`timescale 1ns/1ns
module rfq_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  import rfq_pkg::*;

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } rfq_sync_state_t;

  rfq_sync_state_t st;
  rfq_sync_state_t next_st;

  if (W < 1) begin : g_bad_width
    $error("rfq_sync width must be at least one");
  end

  always_comb begin
    next_st.s1 = d;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q = st.s2;
endmodule : rfq_sync

// file: design/rfq_top.sv
// Summary of operation
// (R01) Handed-over sensor and reference pins float.
// (R02) Handed-over oscillation input pin grounds.
// (R03) Pins start as ports until handed over.
// (R04) Oscillation clock mirrored on monitor pin.
// (R05) Software enables counting clock before other settings.
// (R06) Source field picks one of three oscillators.
// (R07) Low-speed oscillator is used undivided.
// (R08) High-speed oscillator divided by 1,2,4,8.
// (R09) Software keeps time-base counter from overflowing.
// (R10) Gate bit stops or supplies counting clock.
// (R11) Mode field selects DC or AC sensing.
// (R12) DC mode biases elements with steady drive.
// (R13) AC mode toggles bias, one sensor.
// (R14) Each channel keeps its own mode.
// (R15) Event mode counts external input pulses.
// (R16) Continuous bit ignores automatic stop requests.
// (R17) Reference phase first, then sensor phase.
// (R18) Enable bit powers converter; channel bit selects.
// (R19) One channel converts at a time.
// (R20) Source codes: 0 fast B, 1 slow, 2 fast A.
`timescale 1ns/1ns
module rfq_top (
  input wire logic clk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [rfq_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic low_speed_osc,
  input wire logic high_speed_osc_a,
  input wire logic high_speed_osc_b,
  input wire rfq_pkg::rfq_pins_t pins_in,
  output rfq_pkg::rfq_pins_t pins_out,
  output rfq_pkg::rfq_pins_t pins_oe,
  input wire logic ref_stop_req,
  input wire logic sensor_stop_req,
  output logic count_clock,
  output logic cr_osc_clock,
  output logic osc_monitor_out,
  output logic phase_ref,
  output logic phase_sensor_a,
  output logic phase_sensor_b,
  output logic active_channel
);
  import rfq_pkg::*;

  typedef struct packed {
    logic [1:0] count_clock_source_sel;
    logic [1:0] count_clock_divider;
    logic count_clock_gate_en;
    logic converter_en;
    logic channel_sel;
    rfq_chan_cfg_t [1:0] cfg;
    logic [1:0] handover;
    rfq_phase_t phase;
    logic auto_stop;
    logic src_prev;
    logic osc_prev;
    logic ac_drive;
    logic count_clock;
    logic cr_osc_clock;
    logic monitor;
    rfq_pins_t pins_out;
    rfq_pins_t pins_oe;
    logic ack;
    logic [31:0] rdat;
    logic [2:0] phase_hot;
  } rfq_top_state_t;

  rfq_top_state_t st;
  rfq_top_state_t next_st;
  logic [4:0] sync_q;
  logic div_tick;
  logic src_lvl;
  logic src_edge;
  logic osc_lvl;
  logic osc_edge;
  logic running;
  logic bus_req;
  logic wr;
  logic start_ok;
  logic act;
  logic drive_lvl;
  logic [31:0] clk_word;
  logic [31:0] ctl_word;
  logic [31:0] trg_word;
  logic [31:0] pin_word;
  logic [31:0] stat_word;
  logic [31:0] wv;
  rfq_chan_cfg_t cur_cfg;

  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    return (old_v & ~m) | (new_v & m);
  endfunction : lane_merge

  // Oscillator pins and oscillation inputs come from outside this clock domain.
  rfq_sync #(.W(5)) u_sync (
    .clk(clk),
    .nrst(nrst),
    .d({pins_in.osc_clock_input_pin, high_speed_osc_b, high_speed_osc_a, low_speed_osc}),
    .q(sync_q)
  );

  rfq_div #(.CNT_W(3)) u_div (
    .clk(clk),
    .nrst(nrst),
    .src_edge(src_edge),
    .bypass(st.count_clock_source_sel == SRC_LS),
    .div_sel(st.count_clock_divider),
    .tick(div_tick)
  );

  always_comb begin
    case (st.count_clock_source_sel) // [R06] [R20]
      SRC_HS_B: src_lvl = sync_q[2];
      SRC_LS: src_lvl = sync_q[0];
      SRC_HS_A: src_lvl = sync_q[1];
      default: src_lvl = 1'b0;
    endcase
  end

  assign src_edge = src_lvl & ~st.src_prev;
  assign osc_lvl = st.channel_sel ? sync_q[4] : sync_q[3];
  assign osc_edge = osc_lvl & ~st.osc_prev;
  assign running = (st.phase != PH_IDLE);
  assign cur_cfg = st.cfg[st.channel_sel];
  assign bus_req = wb_cyc_i && wb_stb_i && !st.ack;
  assign wr = bus_req && wb_we_i;

  assign clk_word = {23'h0, st.count_clock_gate_en, 2'h0, st.count_clock_divider, 2'h0,
                     st.count_clock_source_sel};
  assign ctl_word = {20'h0, st.cfg[1], st.cfg[0], 2'h0, st.channel_sel, st.converter_en};
  assign trg_word = {29'h0, st.phase == PH_SENS_B, st.phase == PH_SENS_A, st.phase == PH_REF};
  assign pin_word = {30'h0, st.handover};
  assign stat_word = {28'h0, st.auto_stop, st.channel_sel, running,
                      st.count_clock_gate_en && (st.count_clock_source_sel != SRC_RSVD)};

  always_comb begin
    next_st = st;
    wv = '0;
    start_ok = 1'b0;
    act = 1'b0;
    drive_lvl = 1'b0;
    next_st.src_prev = src_lvl;
    next_st.osc_prev = osc_lvl;
    next_st.ack = bus_req;
    if (bus_req) begin
      case (wb_adr_i[7:2])
        CLK_REG_OFS[7:2]: next_st.rdat = clk_word;
        CTL_REG_OFS[7:2]: next_st.rdat = ctl_word;
        TRG_REG_OFS[7:2]: next_st.rdat = trg_word;
        PIN_REG_OFS[7:2]: next_st.rdat = pin_word;
        STAT_REG_OFS[7:2]: next_st.rdat = stat_word;
        default: next_st.rdat = '0;
      endcase
    end
    if (wr) begin
      case (wb_adr_i[7:2])
        CLK_REG_OFS[7:2]: begin
          wv = lane_merge(clk_word, wb_dat_i, wb_sel_i);
          next_st.count_clock_source_sel = wv[CLK_SRC_LSB +: 2]; // [R06]
          next_st.count_clock_divider = wv[CLK_DIV_LSB +: 2]; // [R08]
          next_st.count_clock_gate_en = wv[CLK_GATE_BIT]; // [R10]
        end
        CTL_REG_OFS[7:2]: begin
          wv = lane_merge(ctl_word, wb_dat_i, wb_sel_i);
          next_st.converter_en = wv[CTL_EN_BIT]; // [R18]
          // Channel and mode stay frozen while a phase runs.
          if (!running) begin // [R19]
            next_st.channel_sel = wv[CTL_CHAN_BIT]; // [R18]
            next_st.cfg[0] = wv[CTL_CFG_LSB +: CFG_W]; // [R14]
            next_st.cfg[1] = wv[CTL_CFG_LSB + CFG_W +: CFG_W]; // [R14]
          end
        end
        TRG_REG_OFS[7:2]: begin
          wv = lane_merge(trg_word, wb_dat_i, wb_sel_i);
          start_ok = st.converter_en && st.count_clock_gate_en && st.handover[st.channel_sel] &&
                     (cur_cfg.event_counter_en || cur_cfg.osc_mode_sel == MODE_DC ||
                      cur_cfg.osc_mode_sel == MODE_AC); // [R11]
          if (!running) begin
            if (start_ok) begin
              // Reference wins over the sensors when several bits are set.
              if (wv[TRG_REF_BIT]) begin // [R17]
                next_st.phase = PH_REF;
                next_st.auto_stop = 1'b0;
              end else if (wv[TRG_SA_BIT]) begin
                next_st.phase = PH_SENS_A;
                next_st.auto_stop = 1'b0;
              end else if (wv[TRG_SB_BIT]) begin
                next_st.phase = PH_SENS_B;
                next_st.auto_stop = 1'b0;
              end
            end
          end else if ((st.phase == PH_REF && !wv[TRG_REF_BIT]) ||
                       (st.phase == PH_SENS_A && !wv[TRG_SA_BIT]) ||
                       (st.phase == PH_SENS_B && !wv[TRG_SB_BIT])) begin // [R16]
            next_st.phase = PH_IDLE;
            next_st.auto_stop = 1'b0;
          end
        end
        PIN_REG_OFS[7:2]: begin
          wv = lane_merge(pin_word, wb_dat_i, wb_sel_i);
          next_st.handover = wv[1:0]; // [R03]
        end
        default: begin
        end
      endcase
    end
    // Automatic stops come after the bus so that their flag wins over a software stop.
    if (running && !cur_cfg.continuous_osc_en) begin // [R16]
      if ((st.phase == PH_REF && ref_stop_req) ||
          (st.phase != PH_REF && sensor_stop_req)) begin
        next_st.phase = PH_IDLE;
        next_st.auto_stop = 1'b1;
      end
    end
    if (!st.converter_en) begin // [R18]
      next_st.phase = PH_IDLE;
    end
    next_st.phase_hot = {next_st.phase == PH_SENS_B, next_st.phase == PH_SENS_A,
                         next_st.phase == PH_REF}; // [R17]
    next_st.count_clock = div_tick && st.count_clock_gate_en; // [R10]
    next_st.cr_osc_clock = running && osc_edge; // [R15]
    next_st.monitor = running && osc_lvl; // [R04]
    next_st.ac_drive = running ? (st.ac_drive ^ osc_edge) : 1'b0; // [R13]
    drive_lvl = (cur_cfg.osc_mode_sel == MODE_AC) ? st.ac_drive : 1'b1; // [R12] [R13]
    next_st.pins_out = '0;
    next_st.pins_oe = '0; // [R01]
    for (int c = 0; c < 2; c++) begin
      act = running && (st.channel_sel == 1'(c)); // [R19]
      if (st.handover[c]) begin // [R03]
        if (!act) begin
          next_st.pins_oe.osc_clock_input_pin[c] = 1'b1; // [R02]
        end else if (!cur_cfg.event_counter_en) begin // [R15]
          case (st.phase) // [R17]
            PH_REF: begin
              next_st.pins_oe.reference_ctrl_pin[c] = 1'b1;
              next_st.pins_out.reference_ctrl_pin[c] = drive_lvl;
            end
            PH_SENS_A: begin
              next_st.pins_oe.sensor_a_ctrl_pin[c] = 1'b1;
              next_st.pins_out.sensor_a_ctrl_pin[c] = drive_lvl;
            end
            PH_SENS_B: begin
              next_st.pins_oe.sensor_b_ctrl_pin[c] = 1'b1;
              next_st.pins_out.sensor_b_ctrl_pin[c] = drive_lvl;
            end
            default: begin
            end
          endcase
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st <= '0;
      st.count_clock_source_sel <= CLK_SRC_RST;
      st.count_clock_divider <= CLK_DIV_RST;
      st.count_clock_gate_en <= CLK_GATE_RST;
      st.channel_sel <= CHAN_SEL_RST;
      st.cfg[0].osc_mode_sel <= MODE_RST;
      st.cfg[1].osc_mode_sel <= MODE_RST;
      st.phase <= PH_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign wb_dat_o = st.rdat;
  assign wb_ack_o = st.ack;
  assign pins_out = st.pins_out;
  assign pins_oe = st.pins_oe;
  assign count_clock = st.count_clock;
  assign cr_osc_clock = st.cr_osc_clock;
  assign osc_monitor_out = st.monitor;
  assign phase_ref = st.phase_hot[0];
  assign phase_sensor_a = st.phase_hot[1];
  assign phase_sensor_b = st.phase_hot[2];
  assign active_channel = st.channel_sel;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_idle_float;
    st.handover[0] && !(running && !st.channel_sel) |=>
      !pins_oe.sensor_a_ctrl_pin[0] && !pins_oe.sensor_b_ctrl_pin[0] &&
      !pins_oe.reference_ctrl_pin[0];
  endproperty
  a_idle_float: assert property (p_idle_float) else $error("idle control pin driven"); // [R01]

  property p_osc_ground;
    st.handover[1] && !(running && st.channel_sel) |=>
      pins_oe.osc_clock_input_pin[1] && !pins_out.osc_clock_input_pin[1];
  endproperty
  a_osc_ground: assert property (p_osc_ground) else $error("oscillation pin not grounded"); // [R02]

  property p_port_owned;
    st.handover == 2'h0 |=> pins_oe == '0;
  endproperty
  a_port_owned: assert property (p_port_owned) else $error("pin driven before handover"); // [R03]

  property p_monitor_quiet;
    !running |=> !osc_monitor_out && !cr_osc_clock;
  endproperty
  a_monitor_quiet: assert property (p_monitor_quiet) else $error("monitor active while idle"); // [R04]

  property p_gate_off;
    !st.count_clock_gate_en |=> !count_clock;
  endproperty
  a_gate_off: assert property (p_gate_off) else $error("count clock passed closed gate"); // [R10]

  property p_rsvd_src;
    (st.count_clock_source_sel == SRC_RSVD) [*3] |=> !count_clock;
  endproperty
  a_rsvd_src: assert property (p_rsvd_src) else $error("reserved source produced clock"); // [R06]

  property p_continuous;
    running && cur_cfg.continuous_osc_en && st.converter_en && !wr &&
      (ref_stop_req || sensor_stop_req) |=> running && $stable(st.phase);
  endproperty
  a_continuous: assert property (p_continuous) else $error("continuous phase stopped"); // [R16]

  property p_auto_stop;
    running && !cur_cfg.continuous_osc_en && st.phase == PH_REF && ref_stop_req |=>
      !running && st.auto_stop;
  endproperty
  a_auto_stop: assert property (p_auto_stop) else $error("reference phase did not stop"); // [R16]

  property p_chan_frozen;
    running ##1 running |-> $stable(st.channel_sel) && $stable(st.cfg);
  endproperty
  a_chan_frozen: assert property (p_chan_frozen) else $error("channel changed mid phase"); // [R19]

  property p_disabled_idle;
    !st.converter_en |=> !running;
  endproperty
  a_disabled_idle: assert property (p_disabled_idle) else $error("ran while disabled"); // [R18]

  property p_ac_drive;
    running && st.phase == PH_SENS_A && cur_cfg.osc_mode_sel == MODE_AC &&
      !cur_cfg.event_counter_en && st.handover[st.channel_sel] ##1 running |->
      pins_out.sensor_a_ctrl_pin[st.channel_sel] == $past(st.ac_drive);
  endproperty
  a_ac_drive: assert property (p_ac_drive) else $error("AC bias not followed"); // [R13]

  property p_event_float;
    running && cur_cfg.event_counter_en |=> !pins_oe.osc_clock_input_pin[active_channel] &&
      !pins_oe.reference_ctrl_pin[active_channel];
  endproperty
  a_event_float: assert property (p_event_float) else $error("event mode drove a pin"); // [R15]

  c_ref_done: cover property (phase_ref ##[1:50] !phase_ref && st.auto_stop);
  c_sens_b_ch1: cover property (phase_sensor_b && active_channel);
  c_monitor: cover property (osc_monitor_out && cur_cfg.continuous_osc_en);
endmodule : rfq_top

// file: tb/rfq_sensor_model.sv
`timescale 1ns/1ns
module rfq_sensor_model (
  input wire logic clk,
  input wire rfq_pkg::rfq_pins_t pins_out,
  input wire rfq_pkg::rfq_pins_t pins_oe,
  input wire logic ext_en,
  input wire logic slow,
  output rfq_pkg::rfq_pins_t pins_in
);
  import rfq_pkg::*;
  logic flip = 1'b0;
  logic [1:0] osc = 2'b00;
  logic [3:0] cnt [2] = '{4'h0, 4'h0};
  logic [1:0] excited;
  // A biased element or an external source makes the channel input oscillate.
  assign excited = pins_oe.reference_ctrl_pin | pins_oe.sensor_a_ctrl_pin
    | pins_oe.sensor_b_ctrl_pin | {2{ext_en}};
  always @(posedge clk) begin
    flip <= ~flip;
    for (int c = 0; c < 2; c++) begin
      if (excited[c] && cnt[c] >= (slow ? 4'h7 : 4'h2)) begin
        osc[c] <= ~osc[c];
        cnt[c] <= 4'h0;
      end else if (excited[c]) begin
        cnt[c] <= cnt[c] + 4'h1;
      end
    end
  end
  // Undriven pads show a level that changes every cycle, never the last driven one; an excited channel's undriven oscillation pin shows its oscillation.
  always_comb begin
    for (int b = 0; b < 8; b++) begin
      pins_in[b] = pins_oe[b] ? pins_out[b] : flip;
    end
    for (int c = 0; c < 2; c++) begin
      if (!pins_oe.osc_clock_input_pin[c] && excited[c]) begin
        pins_in.osc_clock_input_pin[c] = osc[c];
      end
    end
  end
endmodule : rfq_sensor_model

// file: tb/tb.sv
`timescale 1ns/1ns
module tb;
  import rfq_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00, tcnt = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, dat_o;
  logic ls = 1'b0, hsa = 1'b0, hsb = 1'b0;
  logic ref_stop = 1'b0, sens_stop = 1'b0, ext_en = 1'b0, slow = 1'b0;
  logic ack, cclk, cr, mon, ph_ref, ph_a, ph_b, act_ch;
  rfq_pins_t pins_in, pins_out, pins_oe;
  int miscompares = 0;
  int cmp_count = 0;

  rfq_top dut (.clk(clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .low_speed_osc(ls), .high_speed_osc_a(hsa), .high_speed_osc_b(hsb),
    .pins_in(pins_in), .pins_out(pins_out), .pins_oe(pins_oe), .ref_stop_req(ref_stop),
    .sensor_stop_req(sens_stop), .count_clock(cclk), .cr_osc_clock(cr),
    .osc_monitor_out(mon), .phase_ref(ph_ref), .phase_sensor_a(ph_a),
    .phase_sensor_b(ph_b), .active_channel(act_ch));
  rfq_sensor_model partner (.clk(clk), .pins_out(pins_out), .pins_oe(pins_oe),
    .ext_en(ext_en), .slow(slow), .pins_in(pins_in));

  initial begin
    forever #2 clk = ~clk;
  end
  // Oscillator periods of 16, 24 and 40 cycles; 240 cycles hold whole periods of each.
  always @(posedge clk) begin
    tcnt <= (tcnt == 8'hef) ? 8'h00 : tcnt + 8'h01;
    hsa <= tcnt[3];
    hsb <= (tcnt % 8'h18) < 8'h0c;
    ls <= (tcnt % 8'h28) < 8'h14;
  end

  task automatic tally_and_finish;
    $display("Counts: %0d compares, %0d mismatches", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_near(input int got, input int exp);
    chk(32'((got >= exp - 1 && got <= exp + 1) ? exp : got), 32'(exp));
  endtask : chk_near

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
  endtask : settle

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 16);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (ack !== 1'b1) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, ack, 1'b1);
      tally_and_finish;
    end
  endtask : wb

  task automatic count_cc(input int cycles, output int n);
    n = 0;
    repeat (cycles) begin
      @(posedge clk);
      n += (cclk === 1'b1);
    end
  endtask : count_cc

  task automatic t_reset;
    int n;
    wb(1'b0, CLK_REG_OFS, 32'h0);
    chk(rdat, 32'h0);
    wb(1'b0, CTL_REG_OFS, 32'h0);
    chk(rdat, 32'h0);
    wb(1'b0, PIN_REG_OFS, 32'h0);
    chk(rdat, 32'h0);
    chk(32'(pins_oe), 32'h0);
    wb(1'b1, 8'h20, 32'hffffffff);
    wb(1'b0, 8'h20, 32'h0);
    chk(rdat, 32'h0);
    count_cc(64, n);
    chk(n, 0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_clock;
    int n;
    logic [1:0] src [3] = '{SRC_HS_A, SRC_HS_B, SRC_LS};
    int per [3] = '{60, 40, 24};
    for (int s = 0; s < 3; s++) begin
      for (int d = 0; d < 4; d++) begin
        wb(1'b1, CLK_REG_OFS, {23'h0, 1'b1, 2'h0, 2'(d), 2'h0, src[s]});
        settle(16);
        count_cc(960, n);
        chk_near(n, (s == 2) ? per[s] : per[s] >> d);
      end
    end
    wb(1'b1, CLK_REG_OFS, {23'h0, 1'b1, 6'h0, SRC_RSVD});
    settle(16);
    count_cc(240, n);
    chk(n, 0);
    wb(1'b1, CLK_REG_OFS, {23'h0, 1'b0, 6'h0, SRC_HS_A});
    settle(16);
    count_cc(240, n);
    chk(n, 0);
    wb(1'b1, CLK_REG_OFS, {23'h0, 1'b1, 6'h0, SRC_HS_A});
    wb(1'b0, CLK_REG_OFS, 32'h0);
    chk(rdat, 32'h102);
    $display("test clock done");
  endtask : t_clock

  task automatic t_pins;
    rfq_pins_t e;
    e = '0;
    wb(1'b1, PIN_REG_OFS, 32'h1);
    settle(2);
    e.osc_clock_input_pin = 2'b01;
    chk(32'(pins_oe), 32'(e));
    chk(pins_out.osc_clock_input_pin, 2'b00);
    wb(1'b1, PIN_REG_OFS, 32'h3);
    settle(2);
    e.osc_clock_input_pin = 2'b11;
    chk(32'(pins_oe), 32'(e));
    $display("test pins done");
  endtask : t_pins

  task automatic phase_check(input logic [2:0] trg, input logic ac, input logic ch,
    input logic cont);
    int p, tg, h;
    logic prev, nc;
    p = 0;
    tg = 0;
    h = 0;
    nc = ~ch;
    wb(1'b1, TRG_REG_OFS, {29'h0, trg});
    settle(2);
    prev = mon;
    chk({ph_b, ph_a, ph_ref}, trg);
    chk(act_ch, ch);
    chk(pins_oe.osc_clock_input_pin, {nc, ch});
    chk({pins_oe.sensor_b_ctrl_pin[ch], pins_oe.sensor_a_ctrl_pin[ch],
      pins_oe.reference_ctrl_pin[ch]}, trg);
    chk({pins_oe.sensor_b_ctrl_pin[nc], pins_oe.sensor_a_ctrl_pin[nc],
      pins_oe.reference_ctrl_pin[nc]}, 3'h0);
    repeat (48) begin
      @(posedge clk);
      p += (cr === 1'b1);
      tg += (mon !== prev);
      prev = mon;
      h += (|(trg & {pins_out.sensor_b_ctrl_pin[ch], pins_out.sensor_a_ctrl_pin[ch],
        pins_out.reference_ctrl_pin[ch]}) === 1'b1);
    end
    chk_near(p, 8);
    chk(tg > 0, 1'b1);
    chk(ac ? (h > 0 && h < 48) : (h == 48), 1'b1);
    if (trg[0]) begin
      ref_stop <= 1'b1;
    end else begin
      sens_stop <= 1'b1;
    end
    @(posedge clk);
    ref_stop <= 1'b0;
    sens_stop <= 1'b0;
    settle(2);
    chk({ph_b, ph_a, ph_ref}, cont ? trg : 3'h0);
    if (cont) begin
      wb(1'b1, TRG_REG_OFS, 32'h0);
      settle(2);
      chk({ph_b, ph_a, ph_ref}, 3'h0);
    end
    settle(2);
    chk(mon, 1'b0);
  endtask : phase_check

  task automatic t_dc;
    wb(1'b1, CTL_REG_OFS, 32'h1);
    phase_check(3'h1, 1'b0, 1'b0, 1'b0);
    phase_check(3'h2, 1'b0, 1'b0, 1'b0);
    phase_check(3'h4, 1'b0, 1'b0, 1'b0);
    wb(1'b0, STAT_REG_OFS, 32'h0);
    chk(rdat, 32'h9);
    $display("test dc done");
  endtask : t_dc

  task automatic t_modes;
    wb(1'b1, CTL_REG_OFS, 32'h503);
    phase_check(3'h2, 1'b1, 1'b1, 1'b1);
    wb(1'b1, CTL_REG_OFS, 32'h501);
    wb(1'b0, CTL_REG_OFS, 32'h0);
    chk(rdat, 32'h501);
    phase_check(3'h2, 1'b0, 1'b0, 1'b0);
    $display("test modes done");
  endtask : t_modes

  task automatic t_event;
    int p;
    p = 0;
    ext_en <= 1'b1;
    slow <= 1'b1;
    wb(1'b1, CTL_REG_OFS, 32'ha1);
    wb(1'b1, TRG_REG_OFS, 32'h1);
    settle(2);
    chk(ph_ref, 1'b1);
    chk(32'(pins_oe), 32'h2);
    repeat (160) begin
      @(posedge clk);
      p += (cr === 1'b1);
    end
    chk_near(p, 10);
    wb(1'b1, TRG_REG_OFS, 32'h0);
    settle(2);
    chk(ph_ref, 1'b0);
    ext_en <= 1'b0;
    slow <= 1'b0;
    for (int m = 2; m < 4; m++) begin
      wb(1'b1, CTL_REG_OFS, {24'h0, 2'(m), 6'h01});
      wb(1'b1, TRG_REG_OFS, 32'h1);
      settle(2);
      chk(ph_ref, 1'b0);
    end
    $display("test event done");
  endtask : t_event

  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    t_reset;
    t_clock;
    t_pins;
    t_dc;
    t_modes;
    t_event;
    tally_and_finish;
  end
endmodule : tb
